// File: ocr_pkg.sv
// Shared constants and pin bundle for the octal clearable load register
package ocr_pkg;

  localparam int unsigned WIDTH    = 8;
  localparam int unsigned OE_COUNT = 3;

  // Values of the stored word and of the drive enables
  localparam logic [WIDTH-1:0]    WORD_ZERO   = 8'h00;
  localparam logic [WIDTH-1:0]    DRIVE_ALL   = 8'hff;
  localparam logic [WIDTH-1:0]    DRIVE_NONE  = 8'h00;
  localparam logic [OE_COUNT-1:0] ALLOW_ALL_N = 3'h0;

  // Pins that cross into the clk domain, kept together through the synchroniser
  typedef struct packed {
    logic                clock_pulse;
    logic                load_gate_n;
    logic [OE_COUNT-1:0] drive_allow_n;
    logic [WIDTH-1:0]    data;
  } ocr_pins_t;

  localparam ocr_pins_t PINS_IDLE = '{clock_pulse: 1'h0, load_gate_n: 1'h1,
                                      drive_allow_n: 3'h7, data: 8'h00};

endpackage : ocr_pkg

// File: ocr_store_bit.sv
// One storage lane: async-clearable flip-flop with a load strobe
`timescale 1ns/1ps
module ocr_store_bit (
  input  wire logic clk,
  input  wire logic clr_n,
  input  wire logic load,
  input  wire logic d,
  output logic      q_reg
);

  // Clear dominates; otherwise capture only on the load strobe
  always_ff @(posedge clk or negedge clr_n)
  begin
    if (!clr_n)
      q_reg <= 1'h0;
    else if (load)
      q_reg <= d;
  end

endmodule : ocr_store_bit

// File: ocr_top.sv
// Octal clearable load register with gated clock and three drive enables
//
// Operation
// - Eight stored bits, one per data lane, common clock and enable path.
// - Rising clock edge with load gate low and clear high captures the data.
// - Load gate high keeps the stored word unchanged across clock and data changes.
// - Clear low forces the stored word to zero; enabled outputs read low.
// - New data enters only while clear is high.
// - With output enabled, the stored word is driven onto the outputs.
// - Output enables never alter the stored word; loading continues while floating.
// - Outputs are true, not inverted, and float when the enable is high.
// - Several separate active-low output enables let many bus users control drive.
`timescale 1ns/1ps
module ocr_top (
  input  wire logic                         clk,
  input  wire logic                         arst_n,
  input  wire logic                         clock_pulse,
  input  wire logic                         load_gate_n,
  input  wire logic                         wipe_n,
  input  wire logic                         drive_allow_a_n,
  input  wire logic                         drive_allow_b_n,
  input  wire logic                         drive_allow_c_n,
  input  wire logic [ocr_pkg::WIDTH-1:0]    data_in,
  output logic      [ocr_pkg::WIDTH-1:0]    data_out,
  output logic      [ocr_pkg::WIDTH-1:0]    data_oe
);

  ocr_pkg::ocr_pins_t           pins_raw;
  ocr_pkg::ocr_pins_t           pins_s1_reg;
  ocr_pkg::ocr_pins_t           pins_s2_reg;
  logic                         pulse_s3_reg;
  logic                         wipe_s1_reg;
  logic                         wipe_s2_reg;
  logic                         clk_rise;
  logic                         load;
  logic                         clr_n;
  logic                         allow_all;
  logic [ocr_pkg::WIDTH-1:0]    stored;
  logic [ocr_pkg::WIDTH-1:0]    data_oe_reg;
  logic [ocr_pkg::WIDTH-1:0]    data_oe_next;

  // Bundle the pins so all of them see the same synchroniser delay
  assign pins_raw = '{clock_pulse:   clock_pulse,
                      load_gate_n:   load_gate_n,
                      drive_allow_n: {drive_allow_c_n, drive_allow_b_n, drive_allow_a_n},
                      data:          data_in};

  // Two-stage synchroniser; stage one is read only by stage two
  // Every pin sees the same two-edge delay, so data and gate stay aligned with the clock pin
  // Pin levels shorter than one clk period may be missed; the price of running on one clock
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pins_s1_reg <= ocr_pkg::PINS_IDLE;
      pins_s2_reg <= ocr_pkg::PINS_IDLE;
    end
    else
    begin
      pins_s1_reg <= pins_raw;
      pins_s2_reg <= pins_s1_reg;
    end
  end

  // Third stage of the clock pin, only for edge detection
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      pulse_s3_reg <= 1'h0;
    else
      pulse_s3_reg <= pins_s2_reg.clock_pulse;
  end

  // Clear seen in the clk domain; gates loading until it has really released
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wipe_s1_reg <= 1'h0;
      wipe_s2_reg <= 1'h0;
    end
    else
    begin
      wipe_s1_reg <= wipe_n;
      wipe_s2_reg <= wipe_s1_reg;
    end
  end

  // Low-to-high transition of the sampled clock pin
  assign clk_rise = pins_s2_reg.clock_pulse & ~pulse_s3_reg;

  // Load needs an edge, gate low and a released clear
  // Gate and data come through the same stages as the clock pin, so they line up
  assign load = clk_rise & ~pins_s2_reg.load_gate_n & wipe_s2_reg;

  // Clear pin goes straight to the flops; release timing is guarded by wipe_s2_reg above
  // A release right at a clk edge meets flops whose load is held off, so the word stays zero
  // A clear pulse shorter than a clk period still wipes the word but may not delay the next load
  assign clr_n = arst_n & wipe_n;

  // Eight identical storage lanes
  // Each lane clears on its own async input; nothing but clr_n reaches that pin
  genvar lane;
  generate
    for (lane = 0; lane < ocr_pkg::WIDTH; lane++)
    begin : g_lane
      ocr_store_bit u_bit (
        .clk   (clk),
        .clr_n (clr_n),
        .load  (load),
        .d     (pins_s2_reg.data[lane]),
        .q_reg (stored[lane])
      );
    end
  endgenerate

  // True outputs straight from the storage flops; enables never touch them
  assign data_out = stored;

  // Drive only when every enable is low
  // Any single bus user can float the outputs by raising its own enable
  assign allow_all = (pins_s2_reg.drive_allow_n == ocr_pkg::ALLOW_ALL_N);

  always_comb
  begin
    data_oe_next = allow_all ? ocr_pkg::DRIVE_ALL : ocr_pkg::DRIVE_NONE;
  end

  // Output enable register, one bit per lane so pads can take it directly
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      data_oe_reg <= ocr_pkg::DRIVE_NONE;
    else
      data_oe_reg <= data_oe_next;
  end

  // Pads read the registered enable
  assign data_oe = data_oe_reg;

  // Checks sample on clk; pin-side checks count two synchroniser edges plus one register
  // Word checks skip edges where clear is low, since the async clear may land between samples
  // Loaded word equals the sampled data one cycle later
  chk_load_capture: assert property (@(posedge clk) disable iff (!arst_n)
    (load && wipe_n) ##1 wipe_n |-> stored == $past(pins_s2_reg.data))
    else $error("stored word does not match data taken at load");

  // Output shows the data pins as they stood two edges before the load
  chk_pin_to_word: assert property (@(posedge clk) disable iff (!arst_n)
    (load && wipe_n) ##1 wipe_n |-> data_out == $past(data_in, 3))
    else $error("output word differs from data pins at load");

  // Gate high freezes the word
  chk_gate_hold: assert property (@(posedge clk) disable iff (!arst_n)
    (pins_s2_reg.load_gate_n && wipe_n) ##1 wipe_n |-> $stable(stored))
    else $error("stored word changed while load gate high");

  // Gate pin high two edges back keeps the output word still
  chk_gate_pin_hold: assert property (@(posedge clk) disable iff (!arst_n)
    ($past(load_gate_n, 2) && wipe_n) ##1 wipe_n |-> $stable(data_out))
    else $error("output word changed while gate pin high");

  // Clear low shows zero at every sample
  chk_clear_zero: assert property (@(posedge clk) disable iff (!arst_n)
    !wipe_n |-> stored == ocr_pkg::WORD_ZERO)
    else $error("stored word not zero while clear low");

  // Clear low reads low on the outputs
  chk_clear_output: assert property (@(posedge clk) disable iff (!arst_n)
    !wipe_n |-> data_out == ocr_pkg::WORD_ZERO)
    else $error("output word not zero while clear low");

  // Right after clear releases, no load slips in
  chk_clear_blocks: assert property (@(posedge clk) disable iff (!arst_n)
    !wipe_n ##1 wipe_n |=> stored == ocr_pkg::WORD_ZERO)
    else $error("load taken just after clear release");

  // Clear pin low two edges back refuses any load
  chk_wipe_gates_load: assert property (@(posedge clk) disable iff (!arst_n)
    !$past(wipe_n, 2) |-> !load)
    else $error("load taken while clear seen low");

  // Without load the word only moves by clear, whatever the enables do
  chk_enable_no_effect: assert property (@(posedge clk) disable iff (!arst_n)
    (!load && wipe_n) ##1 wipe_n |-> $stable(stored))
    else $error("stored word changed without a load");

  // All three enables low lead to drive after one cycle
  chk_drive_all: assert property (@(posedge clk) disable iff (!arst_n)
    allow_all |=> data_oe == ocr_pkg::DRIVE_ALL)
    else $error("outputs not driven with all enables low");

  // Any enable high floats the outputs after one cycle
  chk_float_any: assert property (@(posedge clk) disable iff (!arst_n)
    !allow_all |=> data_oe == ocr_pkg::DRIVE_NONE)
    else $error("outputs driven with an enable high");

  // Enable pins reach the drive three cycles later
  chk_pin_latency: assert property (@(posedge clk) disable iff (!arst_n)
    ({drive_allow_c_n, drive_allow_b_n, drive_allow_a_n} == ocr_pkg::ALLOW_ALL_N) [*3]
      |=> data_oe == ocr_pkg::DRIVE_ALL)
    else $error("enable pins did not reach drive in three cycles");

  // Any enable pin high floats the outputs three edges later
  chk_float_latency: assert property (@(posedge clk) disable iff (!arst_n)
    ({drive_allow_c_n, drive_allow_b_n, drive_allow_a_n} != ocr_pkg::ALLOW_ALL_N) |-> ##3 data_oe == ocr_pkg::DRIVE_NONE)
    else $error("enable pin high did not float outputs in three cycles");

  // A rise is seen exactly two edges after the pin went high, with the gate low then
  chk_rise_latency: assert property (@(posedge clk) disable iff (!arst_n)
    load |-> $past(clock_pulse, 2) && !$past(clock_pulse, 3)
             && !$past(load_gate_n, 2))
    else $error("load not aligned with a sampled clock pin rise");

  // Reset holds the word at zero and the pads floating
  chk_reset_idle: assert property (@(posedge clk)
    !arst_n ##1 !arst_n |-> data_out == ocr_pkg::WORD_ZERO
                            && data_oe == ocr_pkg::DRIVE_NONE)
    else $error("outputs not idle during reset");

endmodule : ocr_top

// File: ocr_bus_user.sv
// Downstream bus user model: resolves the shared data lanes
`timescale 1ns/1ps
module ocr_bus_user (
  input  wire logic                      clk,
  input  wire logic [ocr_pkg::WIDTH-1:0] data_out,
  input  wire logic [ocr_pkg::WIDTH-1:0] data_oe,
  output logic      [ocr_pkg::WIDTH-1:0] bus
);
  logic [ocr_pkg::WIDTH-1:0] noise_reg = 8'h55;

  // Floating lanes toggle, so a stale word never reads as a match
  always_ff @(posedge clk)
  begin
    noise_reg <= ~noise_reg;
  end

  // Driven lanes show the word, others show noise
  assign bus = (data_oe & data_out) | (~data_oe & noise_reg);
endmodule : ocr_bus_user

// File: test_ocr_top.sv
// Self-checking bench for the octal clearable load register
`timescale 1ns/1ps
module test_ocr_top;
  logic       clk;
  logic       arst_n;
  logic       pulse_pin;
  logic       gate_n;
  logic       wipe_n;
  logic [2:0] en_n;
  logic [7:0] din;
  logic [7:0] dout;
  logic [7:0] doe;
  logic [7:0] bus;
  logic [7:0] exp;
  int         error_cnt = 0;
  int         n_checks = 0;

  ocr_top dut (.clk(clk), .arst_n(arst_n), .clock_pulse(pulse_pin), .load_gate_n(gate_n), .wipe_n(wipe_n),
    .drive_allow_a_n(en_n[0]), .drive_allow_b_n(en_n[1]), .drive_allow_c_n(en_n[2]),
    .data_in(din), .data_out(dout), .data_oe(doe));
  ocr_bus_user user (.clk(clk), .data_out(dout), .data_oe(doe), .bus(bus));

  // 40 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Inputs always move 1 ns after the edge
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task chk(input logic [7:0] seen, input logic [7:0] want);
    n_checks++;
    if (seen !== want)
    begin
      error_cnt++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, want);
    end
  endtask : chk

  // One pin clock pulse, high 2 and low 3 cycles, covers the 3-edge latency
  task pulse(input logic [7:0] d, input logic g);
    din = d;
    gate_n = g;
    pulse_pin = 1'h1;
    cyc(2);
    pulse_pin = 1'h0;
    cyc(3);
  endtask : pulse

  task s_load;
    pulse(8'ha5, 1'h0);
    chk(dout, 8'ha5);
    pulse(8'h5a, 1'h0);
    exp = 8'h5a;
    chk(dout, exp);
  endtask : s_load

  task s_hold;
    pulse(8'h3c, 1'h1);
    chk(dout, exp);
    din = 8'hc3;
    cyc(4);
    chk(dout, exp);
  endtask : s_hold

  task s_clear;
    wipe_n = 1'h0;
    #2;
    chk(dout, ocr_pkg::WORD_ZERO);
    cyc(1);
    pulse(8'hff, 1'h0);
    chk(dout, ocr_pkg::WORD_ZERO);
    wipe_n = 1'h1;
    cyc(3);
    pulse(8'h81, 1'h0);
    exp = 8'h81;
    chk(dout, exp);
  endtask : s_clear

  // Every enable combination; only all-low drives the bus
  task s_enables;
    for (int i = 0; i < 8; i++)
    begin
      en_n = i[2:0];
      cyc(4);
      chk(doe, (i == 0) ? ocr_pkg::DRIVE_ALL : ocr_pkg::DRIVE_NONE);
      if (i == 0)
        chk(bus, exp);
      chk(dout, exp);
    end
    pulse(8'h96, 1'h0);
    exp = 8'h96;
    chk(dout, exp);
    en_n = 3'h0;
    cyc(4);
    chk(bus, exp);
  endtask : s_enables

  task stop_test;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : stop_test

  // Watchdog in case the sequence ever stalls
  initial
  begin
    #100us;
    error_cnt++;
    stop_test();
  end

  initial
  begin
    {arst_n, pulse_pin, gate_n, wipe_n, en_n, din, exp} = {1'h0, 1'h0, 1'h1, 1'h1, 3'h7, 8'h00, 8'h00};
    repeat (8) @(posedge clk);
    #1 arst_n = 1'h1;
    cyc(4);
    chk(dout, ocr_pkg::WORD_ZERO);
    chk(doe, ocr_pkg::DRIVE_NONE);
    s_load();
    s_hold();
    s_clear();
    s_enables();
    stop_test();
  end
endmodule : test_ocr_top
